/* bench/hsad_front_model.sv */
// Behavioural jack contacts answering the measurement link
`timescale 1ns/100ps
`default_nettype none
module hsad_front_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Measurement link
    input wire hsad_pkg::hsad_meas_req_type meas_req,
    output hsad_pkg::hsad_meas_rsp_type meas_rsp,
    // Codes per selection, byte 0 for contact A
    input wire logic [31:0] codes
);
    logic [2:0] cnt_q;
    logic [1:0] sel_q;
    logic slow_q;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 3'h0;
            sel_q <= 2'h0;
            slow_q <= 1'b0;
            meas_rsp <= '0;
        end
        else
        begin
            meas_rsp.done <= 1'b0;
            // Code is junk outside done, so nothing leans on it
            meas_rsp.code <= ~meas_rsp.code;
            if (meas_req.start)
            begin
                cnt_q <= slow_q ? 3'h6 : 3'h1;
                sel_q <= meas_req.sel;
                slow_q <= ~slow_q;
            end
            else if (cnt_q != 3'h0)
            begin
                cnt_q <= cnt_q - 3'h1;
                meas_rsp.done <= (cnt_q == 3'h1);
                meas_rsp.code <= codes[{sel_q, 3'h0} +: 8];
            end
        end
    end
endmodule // hsad_front_model
`default_nettype wire

/* bench/hsad_props.sv */
// Port assertions of the headset accessory detector
`timescale 1ns/100ps
`default_nettype none
module hsad_props (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire hsad_pkg::hsad_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata_q,
    // Measurement link and system side
    input wire hsad_pkg::hsad_meas_req_type meas_req_q,
    input wire logic clk_req_q,
    input wire logic wake_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_issue;
        meas_req_q.start ##1 !meas_req_q.start;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_req.rd) |-> reg_rdata_q == 8'h00)
        else $error("read data outside answer cycle");
    a_unmapped_zero: assert property ($past(reg_req.rd) && $past(reg_req.addr) >= 4'hc |-> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_start_one_pulse: assert property (meas_req_q.start |-> s_issue)
        else $error("start longer than one cycle");
    a_contact_a_source: assert property (meas_req_q.start && meas_req_q.sel == hsad_pkg::MEAS_CONTACT_A
        |-> meas_req_q.src_contact_a && !meas_req_q.src_second_ring) else $error("contact_a not sourced");
    a_ring_source: assert property (meas_req_q.start && meas_req_q.sel == hsad_pkg::MEAS_SECOND_RING
        |-> meas_req_q.src_second_ring && !meas_req_q.src_contact_a) else $error("ring not sourced");
    a_source_cause: assert property ($rose(meas_req_q.src_contact_a) || $rose(meas_req_q.src_second_ring)
        |-> meas_req_q.start) else $error("source without start");
    a_wake_clk_req: assert property (wake_q |-> clk_req_q)
        else $error("wake without clock request");
    a_start_clk_req: assert property (meas_req_q.start |-> clk_req_q)
        else $error("measurement without clock request");
endmodule // hsad_props
bind hsad_top hsad_props u_props (.ref_clk, .arst_n, .reg_req, .reg_rdata_q, .meas_req_q, .clk_req_q, .wake_q);
`default_nettype wire

/* bench/tb_top.sv */
// Register-level testbench of the headset accessory detector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic pin = 1'b0;
    logic clk_req, wake, micbias, ev_any;
    logic [7:0] rdata;
    logic [31:0] codes = 32'hff20_40c0;
    hsad_pkg::hsad_reg_req_type req = '0;
    hsad_pkg::hsad_meas_req_type mreq;
    hsad_pkg::hsad_meas_rsp_type mrsp;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [11:0] rst_tbl [13] = '{12'h078, 12'h102, 12'h201, 12'h340, 12'h420, 12'h508, 12'h610,
        12'h718, 12'h800, 12'h900, 12'ha00, 12'hb1f, 12'hc00};
    always #5 ref_clk = ~ref_clk;
    hsad_top #(.MS_CYC(10)) DUT (.ref_clk, .arst_n, .reg_req(req), .reg_rdata_q(rdata), .jack_det_pin(pin),
        .meas_req_q(mreq), .meas_rsp(mrsp), .clk_req_q(clk_req), .wake_q(wake), .micbias_en_q(micbias),
        .event_any_q(ev_any));
    hsad_front_model u_fe (.ref_clk, .arst_n, .meas_req(mreq), .meas_rsp(mrsp), .codes);
    // ****************************************************
    // Access and check tasks
    // ****************************************************
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) req.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic wait_ms(input int n);
        repeat (n * 10) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Ceiling well above the roughly 2200 cycles of the run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (rst_tbl[i]) rd(rst_tbl[i][11:8], rst_tbl[i][7:0]);
        $display("test reset values done");
        wr(4'h0, 8'h7e);
        @(posedge ref_clk) pin <= 1'b1;
        wait_ms(10);
        chk("wake", 8'h00, {7'h0, wake});
        rd(4'ha, 8'h00);
        wr(4'hb, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h7f);
        wait_ms(10);
        chk("wake", 8'h01, {7'h0, wake});
        chk("event_any", 8'h01, {7'h0, ev_any});
        rd(4'ha, 8'h01);
        wait_ms(80);
        rd(4'h9, 8'h03);
        rd(4'ha, 8'h05);
        wr(4'ha, 8'h07);
        rd(4'ha, 8'h00);
        chk("event_any", 8'h00, {7'h0, ev_any});
        $display("test four pole insertion done");
        codes[31:24] <= 8'h10;
        wait_ms(6);
        rd(4'ha, 8'h08);
        rd(4'h9, 8'h13);
        wr(4'ha, 8'h08);
        codes[31:24] <= 8'h05;
        wait_ms(6);
        rd(4'ha, 8'h00);
        codes[31:24] <= 8'hff;
        wait_ms(6);
        rd(4'ha, 8'h10);
        wr(4'h0, 8'hff);
        wait_ms(1);
        chk("micbias", 8'h01, {7'h0, micbias});
        $display("test buttons done");
        @(posedge ref_clk) pin <= 1'b0;
        wait_ms(5);
        rd(4'ha, 8'h12);
        rd(4'h9, 8'h00);
        chk("micbias", 8'h00, {7'h0, micbias});
        $display("test removal done");
        wr(4'ha, 8'h1f);
        codes[7:0] <= 8'h30;
        @(posedge ref_clk) pin <= 1'b1;
        wait_ms(50);
        rd(4'h9, 8'h01);
        rd(4'ha, 8'h05);
        chk("micbias", 8'h00, {7'h0, micbias});
        wr(4'h2, 8'h03);
        wait_ms(40);
        rd(4'h9, 8'h07);
        chk("micbias", 8'h01, {7'h0, micbias});
        wr(4'h8, 8'h34);
        rd(4'h9, 8'h0b);
        $display("test three pole and reverify done");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire

/* logic/hsad_pkg.sv */
// Constants, register map and carrier types of the headset accessory detector
package hsad_pkg;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [9:0] POLL_MS = 10'h010;
    localparam logic [9:0] BTN_POLL_MS = 10'h002;
    localparam logic [9:0] INS_DEB_MS [8] = '{10'h005, 10'h00a, 10'h014, 10'h032, 10'h064, 10'h0c8, 10'h1f4, 10'h3e8};
    localparam logic [9:0] REM_DEB_MS [4] = '{10'h001, 10'h005, 10'h00a, 10'h014};
    localparam logic [9:0] DET3_MS [4] = '{10'h020, 10'h040, 10'h080, 10'h100};
    localparam logic [9:0] DET4_MS [4] = '{10'h040, 10'h080, 10'h100, 10'h200};
    // Codes for 200, 500, 750 and 100 ohms
    localparam logic [7:0] MIC_THR_CODE [4] = '{8'h32, 8'h7d, 8'hbb, 8'h19};
    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_THRESH = 4'h2;
    localparam logic [3:0] ADDR_LOAD_THR = 4'h3;
    localparam logic [3:0] ADDR_BTN_PRESS = 4'h4;
    localparam logic [3:0] ADDR_BTN_ID0 = 4'h5;
    localparam logic [3:0] ADDR_OVR = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    localparam logic [3:0] ADDR_EVENT = 4'ha;
    localparam logic [3:0] ADDR_MASK = 4'hb;
    localparam logic [7:0] CTRL_RST = 8'h78;
    localparam logic [7:0] CFG_RST = 8'h02;
    localparam logic [7:0] THRESH_RST = 8'h01;
    localparam logic [7:0] LOAD_THR_RST = 8'h40;
    localparam logic [7:0] BTN_PRESS_RST = 8'h20;
    localparam logic [7:0] BTN_ID_RST [3] = '{8'h08, 8'h10, 8'h18};
    localparam logic [7:0] OVR_RST = 8'h00;
    localparam logic [4:0] MASK_RST = 5'h1f;
    // CTRL bits
    localparam int unsigned CTRL_ACC_EN = 0;
    localparam int unsigned CTRL_SYS_ACT = 1;
    localparam int unsigned CTRL_PIN_POL = 2;
    localparam int unsigned CTRL_TYPE_EN = 3;
    localparam int unsigned CTRL_ORDER_EN = 4;
    localparam int unsigned CTRL_BTN_EN = 5;
    localparam int unsigned CTRL_LOAD_EN = 6;
    localparam int unsigned CTRL_MICBIAS = 7;
    // OVR bits
    localparam int unsigned OVR_TYPE = 0;
    localparam int unsigned OVR_TYPE_VAL = 1;
    localparam int unsigned OVR_ORDER = 2;
    localparam int unsigned OVR_ORDER_VAL = 3;
    localparam int unsigned OVR_LOAD = 4;
    localparam int unsigned OVR_LOAD_VAL = 5;
    // EVENT bits
    localparam int unsigned EV_INS = 0;
    localparam int unsigned EV_REM = 1;
    localparam int unsigned EV_DONE = 2;
    localparam int unsigned EV_PRESS = 3;
    localparam int unsigned EV_REL = 4;
    // ****************************************************
    // Types
    // ****************************************************
    typedef enum logic [1:0] {MEAS_CONTACT_A, MEAS_SECOND_RING, MEAS_LOAD, MEAS_BUTTON} hsad_meas_sel_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hsad_reg_req_type;
    typedef struct packed {
        logic start;
        hsad_meas_sel_type sel;
        logic src_contact_a;
        logic src_second_ring;
        logic gnd_switch;
    } hsad_meas_req_type;
    typedef struct packed {
        logic done;
        logic [7:0] code;
    } hsad_meas_rsp_type;
endpackage

/* logic/hsad_top.sv */
// Headset accessory detector: jack sensing, type, pin order, load and button detection
//
// Function
// - Detection runs only while detect enable set
// - Jack sensing needs system active and enable
// - Clock requested only while sensing or debouncing
// - Insertion enters mic detect, contact A sourced
// - Below threshold means 3-pole, then poll removal
// - 3-pole keeps re-verifying by periodic pulses
// - Above threshold means 4-pole
// - Pin order by comparing two sourced voltages
// - Load impedance picks headphone or line out
// - Button state polls, no id without bias
// - Bias on lets button identity be measured
// - Further presses ignored until release
// - Type, pin order and load results overridable, every result readable
// - Per measurement enables, per event masks
// - Mic threshold selects 100/200/500/750 ohms
// - Insertion debounce from 5 ms to 1 s
// - Detection duration by rate, then complete event
// - Pin order only for 4-pole, overridable
// - Pin order reported, valid after complete
// - Separate insertion and removal events
// - Events maskable, cleared by writing one
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module hsad_top #(
    parameter int unsigned MS_CYC = hsad_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register port
    input wire hsad_pkg::hsad_reg_req_type reg_req,
    output logic [7:0] reg_rdata_q,
    // Jack detect pin
    input wire logic jack_det_pin,
    // Measurement front end
    output hsad_pkg::hsad_meas_req_type meas_req_q,
    input wire hsad_pkg::hsad_meas_rsp_type meas_rsp,
    // System side
    output logic clk_req_q,
    output logic wake_q,
    output logic micbias_en_q,
    output logic event_any_q
);
    localparam int TW = $clog2(MS_CYC + 1);

    typedef enum logic [3:0] {ST_IDLE, ST_INS_DEB, ST_MIC_DET, ST_ORDER_A, ST_ORDER_B, ST_LOAD_DET,
        ST_WAIT_DONE, ST_JACK_POLL, ST_BUTTON, ST_REM_DEB} hsad_state_type;

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0] ctrl_q, cfg_q, thresh_q, load_thr_q, btn_press_q, ovr_q;
    logic [7:0] btn_id_q [3];
    logic [4:0] ev_q, ev_set_q, mask_q;
    hsad_state_type state_q, ret_q;
    logic [2:0] pin_s_q;
    logic pin_lvl_q;
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    logic [9:0] deb_ms_q, det_ms_q, poll_ms_q;
    logic busy_q, inserted_q, four_q, order_q, line_q, complete_q;
    logic held_q, id_valid_q;
    logic [1:0] btn_id_res_q;
    logic [7:0] va_q;

    wire wr_hit = reg_req.wr;
    wire [4:0] ev_clr = (wr_hit && reg_req.addr == hsad_pkg::ADDR_EVENT) ? reg_req.wdata[4:0] : 5'h00;
    wire enabled = ctrl_q[hsad_pkg::CTRL_ACC_EN] & ctrl_q[hsad_pkg::CTRL_SYS_ACT];
    wire present = pin_lvl_q == ctrl_q[hsad_pkg::CTRL_PIN_POL];
    wire type_en = ctrl_q[hsad_pkg::CTRL_TYPE_EN];
    wire order_en = ctrl_q[hsad_pkg::CTRL_ORDER_EN];
    wire btn_en = ctrl_q[hsad_pkg::CTRL_BTN_EN];
    wire load_en = ctrl_q[hsad_pkg::CTRL_LOAD_EN];
    wire [7:0] code = meas_rsp.code;
    wire done = busy_q & meas_rsp.done;
    wire [7:0] mic_thr = hsad_pkg::MIC_THR_CODE[thresh_q[1:0]];
    // overrides applied on top of measured results
    wire four_eff = ovr_q[hsad_pkg::OVR_TYPE] ? ovr_q[hsad_pkg::OVR_TYPE_VAL] : four_q;
    wire order_eff = ovr_q[hsad_pkg::OVR_ORDER] ? ovr_q[hsad_pkg::OVR_ORDER_VAL] : order_q;
    wire line_eff = ovr_q[hsad_pkg::OVR_LOAD] ? ovr_q[hsad_pkg::OVR_LOAD_VAL] : line_q;
    wire [9:0] ins_deb_ms = hsad_pkg::INS_DEB_MS[cfg_q[2:0]];
    wire [9:0] rem_deb_ms = hsad_pkg::REM_DEB_MS[cfg_q[4:3]];
    // detection duration depends on jack type
    wire [9:0] det_len = four_eff ? hsad_pkg::DET4_MS[cfg_q[6:5]] : hsad_pkg::DET3_MS[cfg_q[6:5]];
    wire deb_run = state_q == ST_INS_DEB || state_q == ST_REM_DEB;
    wire det_run = state_q != ST_IDLE && state_q != ST_INS_DEB;
    wire poll_due = poll_ms_q >= (state_q == ST_BUTTON ? hsad_pkg::BTN_POLL_MS : hsad_pkg::POLL_MS);
    wire meas_state = state_q == ST_MIC_DET || state_q == ST_ORDER_A || state_q == ST_ORDER_B
        || state_q == ST_LOAD_DET;
    wire poll_go = (state_q == ST_JACK_POLL && type_en && poll_due) || (state_q == ST_BUTTON && btn_en && poll_due);
    wire issue = !busy_q && (meas_state || poll_go);
    wire hsad_pkg::hsad_meas_sel_type sel_w = (state_q == ST_ORDER_B) ? hsad_pkg::MEAS_SECOND_RING :
        (state_q == ST_LOAD_DET) ? hsad_pkg::MEAS_LOAD :
        (state_q == ST_BUTTON) ? hsad_pkg::MEAS_BUTTON : hsad_pkg::MEAS_CONTACT_A;
    wire press = code < btn_press_q;
    wire four_meas = code > mic_thr;
    wire [3:0] after_mic = four_meas ? (order_en ? ST_ORDER_A : (load_en ? ST_LOAD_DET : ST_WAIT_DONE))
        : (load_en ? ST_LOAD_DET : ST_WAIT_DONE);

    // ****************************************************
    // Button identity
    // ****************************************************
    wire [2:0] above;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_btn
            assign above[gi] = code >= btn_id_q[gi];
        end
    endgenerate
    wire [1:0] btn_id_w = 2'({1'b0, above[0]} + {1'b0, above[1]} + {1'b0, above[2]});

    // ****************************************************
    // Register read
    // ****************************************************
    wire [7:0] status_w = {id_valid_q, btn_id_res_q, held_q, line_eff, order_eff, four_eff, inserted_q};
    wire [7:0] rd_mux = (reg_req.addr == hsad_pkg::ADDR_CTRL) ? ctrl_q :
        (reg_req.addr == hsad_pkg::ADDR_CFG) ? cfg_q :
        (reg_req.addr == hsad_pkg::ADDR_THRESH) ? thresh_q :
        (reg_req.addr == hsad_pkg::ADDR_LOAD_THR) ? load_thr_q :
        (reg_req.addr == hsad_pkg::ADDR_BTN_PRESS) ? btn_press_q :
        (reg_req.addr == hsad_pkg::ADDR_BTN_ID0) ? btn_id_q[0] :
        (reg_req.addr == 4'(hsad_pkg::ADDR_BTN_ID0 + 4'h1)) ? btn_id_q[1] :
        (reg_req.addr == 4'(hsad_pkg::ADDR_BTN_ID0 + 4'h2)) ? btn_id_q[2] :
        (reg_req.addr == hsad_pkg::ADDR_OVR) ? ovr_q :
        (reg_req.addr == hsad_pkg::ADDR_STATUS) ? status_w :
        (reg_req.addr == hsad_pkg::ADDR_EVENT) ? {3'h0, ev_q} :
        (reg_req.addr == hsad_pkg::ADDR_MASK) ? {3'h0, mask_q} : 8'h00;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata_q <= 8'h00;
        else
            reg_rdata_q <= reg_req.rd ? rd_mux : 8'h00;
    end

    // ****************************************************
    // Register write
    // ****************************************************
    // host controls, enables, thresholds, overrides
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= hsad_pkg::CTRL_RST;
            cfg_q <= hsad_pkg::CFG_RST;
            thresh_q <= hsad_pkg::THRESH_RST;
            load_thr_q <= hsad_pkg::LOAD_THR_RST;
            btn_press_q <= hsad_pkg::BTN_PRESS_RST;
            btn_id_q <= hsad_pkg::BTN_ID_RST;
            ovr_q <= hsad_pkg::OVR_RST;
            mask_q <= hsad_pkg::MASK_RST;
        end
        else if (wr_hit)
        begin
            unique case (reg_req.addr)
                hsad_pkg::ADDR_CTRL: ctrl_q <= reg_req.wdata;
                hsad_pkg::ADDR_CFG: cfg_q <= {1'b0, reg_req.wdata[6:0]};
                hsad_pkg::ADDR_THRESH: thresh_q <= {6'h00, reg_req.wdata[1:0]};
                hsad_pkg::ADDR_LOAD_THR: load_thr_q <= reg_req.wdata;
                hsad_pkg::ADDR_BTN_PRESS: btn_press_q <= reg_req.wdata;
                4'h5: btn_id_q[0] <= reg_req.wdata;
                4'h6: btn_id_q[1] <= reg_req.wdata;
                4'h7: btn_id_q[2] <= reg_req.wdata;
                hsad_pkg::ADDR_OVR: ovr_q <= {2'h0, reg_req.wdata[5:0]};
                hsad_pkg::ADDR_MASK: mask_q <= reg_req.wdata[4:0];
                default: ;
            endcase
        end
    end

    // ****************************************************
    // Events
    // ****************************************************
    // sticky events, write one clears, set wins
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ev_q <= 5'h00;
            event_any_q <= 1'b0;
        end
        else
        begin
            ev_q <= (ev_q & ~ev_clr) | ev_set_q;
            // per event mask gates the summary only
            event_any_q <= |(ev_q & ~mask_q);
        end
    end

    // ****************************************************
    // Pin synchroniser and millisecond timebase
    // ****************************************************
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s_q <= 3'h0;
            pin_lvl_q <= 1'b0;
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            pin_s_q <= {pin_s_q[1:0], jack_det_pin};
            if (pin_s_q[1] == pin_s_q[2])
                pin_lvl_q <= pin_s_q[2];
            tick_q <= tick_cnt_q == TW'(MS_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == TW'(MS_CYC - 1)) ? '0 : TW'(tick_cnt_q + 1'b1);
        end
    end

    // Counters saturate so a long idle poll cannot wrap
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            deb_ms_q <= 10'h000;
            det_ms_q <= 10'h000;
            poll_ms_q <= 10'h000;
        end
        else
        begin
            deb_ms_q <= !deb_run ? 10'h000 : deb_ms_q + {9'h000, tick_q && deb_ms_q != 10'h3ff};
            det_ms_q <= !det_run ? 10'h000 : det_ms_q + {9'h000, tick_q && det_ms_q != 10'h3ff};
            poll_ms_q <= (issue || busy_q) ? 10'h000 : poll_ms_q + {9'h000, tick_q && poll_ms_q != 10'h3ff};
        end
    end

    // ****************************************************
    // Detection sequence
    // ****************************************************
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            ret_q <= ST_IDLE;
            meas_req_q <= '0;
            busy_q <= 1'b0;
            ev_set_q <= 5'h00;
            inserted_q <= 1'b0;
            four_q <= 1'b0;
            order_q <= 1'b0;
            line_q <= 1'b0;
            complete_q <= 1'b0;
            held_q <= 1'b0;
            id_valid_q <= 1'b0;
            btn_id_res_q <= 2'h0;
            va_q <= 8'h00;
        end
        else
        begin
            ev_set_q <= 5'h00;
            meas_req_q.start <= issue;
            if (issue)
            begin
                // contact A sourced with second ring grounded in mic detect and jack poll only
                meas_req_q.sel <= sel_w;
                meas_req_q.src_contact_a <= sel_w == hsad_pkg::MEAS_CONTACT_A;
                meas_req_q.src_second_ring <= sel_w == hsad_pkg::MEAS_SECOND_RING;
                meas_req_q.gnd_switch <= state_q == ST_MIC_DET || state_q == ST_JACK_POLL;
                busy_q <= 1'b1;
            end
            else if (done)
            begin
                busy_q <= 1'b0;
                meas_req_q.src_contact_a <= 1'b0;
                meas_req_q.src_second_ring <= 1'b0;
                meas_req_q.gnd_switch <= 1'b0;
            end
            if (!enabled)
            begin
                state_q <= ST_IDLE;
                busy_q <= 1'b0;
                meas_req_q <= '0;
                inserted_q <= 1'b0;
                complete_q <= 1'b0;
                held_q <= 1'b0;
            end
            else if (det_run && state_q != ST_REM_DEB && !present)
            begin
                ret_q <= state_q;
                state_q <= ST_REM_DEB;
                busy_q <= 1'b0;
                meas_req_q <= '0;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                        if (present)
                            state_q <= ST_INS_DEB;
                    ST_INS_DEB:
                        if (!present)
                            state_q <= ST_IDLE;
                        else if (deb_ms_q >= ins_deb_ms)
                        begin
                            inserted_q <= 1'b1;
                            ev_set_q[hsad_pkg::EV_INS] <= 1'b1;
                            four_q <= 1'b0;
                            state_q <= type_en ? ST_MIC_DET : (load_en ? ST_LOAD_DET : ST_WAIT_DONE);
                        end
                    ST_MIC_DET:
                        if (done)
                        begin
                            four_q <= four_meas;
                            state_q <= hsad_state_type'(after_mic);
                        end
                    ST_ORDER_A:
                        if (done)
                        begin
                            va_q <= code;
                            state_q <= ST_ORDER_B;
                        end
                    ST_ORDER_B:
                        // higher voltage contact is the mic
                        if (done)
                        begin
                            order_q <= !(va_q > code);
                            state_q <= load_en ? ST_LOAD_DET : ST_WAIT_DONE;
                        end
                    ST_LOAD_DET:
                        if (done)
                        begin
                            line_q <= code > load_thr_q;
                            state_q <= ST_WAIT_DONE;
                        end
                    ST_WAIT_DONE:
                        if (det_ms_q >= det_len)
                        begin
                            complete_q <= 1'b1;
                            ev_set_q[hsad_pkg::EV_DONE] <= 1'b1;
                            state_q <= (four_eff && btn_en) ? ST_BUTTON : ST_JACK_POLL;
                        end
                    ST_JACK_POLL:
                        if (done && !four_eff && four_meas)
                        begin
                            complete_q <= 1'b0;
                            state_q <= ST_MIC_DET;
                        end
                    ST_BUTTON:
                        if (done)
                        begin
                            // one press at a time, id only with bias
                            if (!held_q && press)
                            begin
                                held_q <= 1'b1;
                                ev_set_q[hsad_pkg::EV_PRESS] <= 1'b1;
                                btn_id_res_q <= ctrl_q[hsad_pkg::CTRL_MICBIAS] ? btn_id_w : 2'h0;
                                id_valid_q <= ctrl_q[hsad_pkg::CTRL_MICBIAS];
                            end
                            else if (held_q && !press)
                            begin
                                held_q <= 1'b0;
                                ev_set_q[hsad_pkg::EV_REL] <= 1'b1;
                            end
                        end
                    ST_REM_DEB:
                        if (present)
                            state_q <= ret_q;
                        else if (deb_ms_q >= rem_deb_ms)
                        begin
                            state_q <= ST_IDLE;
                            ev_set_q[hsad_pkg::EV_REM] <= 1'b1;
                            inserted_q <= 1'b0;
                            four_q <= 1'b0;
                            order_q <= 1'b0;
                            line_q <= 1'b0;
                            complete_q <= 1'b0;
                            held_q <= 1'b0;
                            id_valid_q <= 1'b0;
                            btn_id_res_q <= 2'h0;
                        end
                endcase
            end
        end
    end

    // ****************************************************
    // System side outputs
    // ****************************************************
    // the clock is only needed while something changes or runs
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_req_q <= 1'b0;
            wake_q <= 1'b0;
            micbias_en_q <= 1'b0;
        end
        else
        begin
            clk_req_q <= enabled && (state_q != ST_IDLE || present);
            wake_q <= enabled && present;
            // host bias only reaches a 4-pole jack
            micbias_en_q <= ctrl_q[hsad_pkg::CTRL_MICBIAS] && inserted_q && four_eff && complete_q;
        end
    end
endmodule // hsad_top
`default_nettype wire
